//--- common/cwc_pkg.sv
// Purpose: Shared constants and types for the CAN transceiver mode and wake control
// Assumes: 16-bit SPI frames, 50 MHz mclk
// Notes:   State enums use their declaration order as the code

package cwc_pkg;

	// --------------------------------------------------------------
	// Register addresses
	// --------------------------------------------------------------
	localparam logic [6:0] ADDR_MODE = 7'h01;
	localparam logic [6:0] ADDR_STAT = 7'h03;
	localparam logic [6:0] ADDR_CANC = 7'h20;
	localparam logic [6:0] ADDR_WAKC = 7'h23;
	localparam logic [6:0] ADDR_EVT  = 7'h63;

	// --------------------------------------------------------------
	// Field codes and bit positions
	// --------------------------------------------------------------
	localparam logic [2:0] MC_SLEEP   = 3'h1;
	localparam logic [2:0] MC_STANDBY = 3'h4;
	localparam logic [2:0] MC_NORMAL  = 3'h7;

	localparam int ST_CAUSE_BIT = 7;
	localparam int ST_OTW_BIT   = 6;
	localparam int ST_FNP_BIT   = 5;
	localparam int CC_SELECTIVE_CONFIG_VALID_BIT = 5;
	localparam int CC_SELECTIVE_WAKE_ENABLE_BIT  = 4;
	localparam int WK_EN_BIT    = 0;
	localparam int EV_WAKE_BIT  = 0;

	localparam logic [1:0] XM_OFFLINE = 2'h0;
	localparam logic [1:0] XM_ACT_UV  = 2'h1;
	localparam logic [1:0] XM_ACT_NUV = 2'h2;
	localparam logic [1:0] XM_LISTEN  = 2'h3;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_CANC = 8'h00;
	localparam logic [7:0] RST_WAKC = 8'h01;
	localparam logic [10:0] RST_SYNC = 11'h280;

	// --------------------------------------------------------------
	// Frame and cycle counts
	// --------------------------------------------------------------
	localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
	localparam logic [4:0] SPI_HDR_BITS   = 5'h08;
	localparam logic [3:0] FILT_CYC       = 4'h4;
	localparam logic [7:0] STARTUP_CYC    = 8'h64;

	// --------------------------------------------------------------
	// State types
	// --------------------------------------------------------------
	typedef enum logic [2:0] {DM_OFF, DM_STANDBY, DM_NORMAL, DM_SLEEP, DM_OVERTEMP} cwc_dev_t;
	typedef enum logic [2:0] {XS_OFF, XS_OFFLINE, XS_BIAS, XS_LISTEN, XS_ACTIVE} cwc_xcv_t;
	typedef enum logic [1:0] {WS_IDLE, WS_DOM1, WS_REC, WS_DOM2} cwc_wake_t;

endpackage : cwc_pkg

//--- logic/cwc_wake_det.sv
// Purpose: Bus glitch filter and standard wake-up pattern detector
// Assumes: dom_in already synchronised to clk
// Notes:   Counts are in clk cycles

`timescale 1ns/10ps

module cwc_wake_det
	import cwc_pkg::*;
#(
	parameter logic [23:0] DOM_MIN_CYC = 24'h000032,
	parameter logic [23:0] REC_MIN_CYC = 24'h000032,
	parameter logic [23:0] WAKE_TO_CYC = 24'h00c350
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic dom_in,
	output logic      filt_dom,
	output logic      wake_pulse
);

	// --------------------------------------------------------------
	// Input filter
	// --------------------------------------------------------------
	logic [3:0]  flt_cnt_ff;
	logic        filt_ff;
	cwc_wake_t   st_ff;
	logic [23:0] ph_cnt_ff;
	logic [23:0] tmr_ff;
	logic        pulse_ff;

	wire         differs  = dom_in != filt_ff;
	wire         flt_done = differs && (flt_cnt_ff == FILT_CYC - 4'h1);

	always_ff @(posedge clk)
	begin
		if (rst)
			flt_cnt_ff <= 4'h0;
		else
			flt_cnt_ff <= (differs && !flt_done) ? flt_cnt_ff + 4'h1 : 4'h0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			filt_ff <= 1'b0;
		else if (flt_done)
			filt_ff <= dom_in;
	end

	// --------------------------------------------------------------
	// Pattern sequencer
	// --------------------------------------------------------------
	wire timeout = (st_ff != WS_IDLE) && (tmr_ff >= WAKE_TO_CYC);
	wire dom_ok  = ph_cnt_ff >= DOM_MIN_CYC;
	wire rec_ok  = ph_cnt_ff >= REC_MIN_CYC;

	always_ff @(posedge clk)
	begin
		if (rst || !enable || timeout)
		begin
			st_ff     <= WS_IDLE;
			ph_cnt_ff <= 24'h0;
			tmr_ff    <= 24'h0;
			pulse_ff  <= 1'b0;
		end
		else
		begin
			pulse_ff <= 1'b0;
			tmr_ff   <= (st_ff == WS_IDLE) ? 24'h0 : tmr_ff + 24'h1;
			unique case (st_ff)
				WS_IDLE:
					if (filt_ff)
					begin
						st_ff     <= WS_DOM1;
						ph_cnt_ff <= 24'h1;
					end
				WS_DOM1:
					if (filt_ff)
						ph_cnt_ff <= ph_cnt_ff + 24'h1;
					else if (dom_ok)
					begin
						st_ff     <= WS_REC;
						ph_cnt_ff <= 24'h1;
					end
				WS_REC:
					if (!filt_ff)
						ph_cnt_ff <= ph_cnt_ff + 24'h1;
					else if (rec_ok)
					begin
						st_ff     <= WS_DOM2;
						ph_cnt_ff <= 24'h1;
					end
				WS_DOM2:
					if (filt_ff && ph_cnt_ff + 24'h1 >= DOM_MIN_CYC)
					begin
						st_ff    <= WS_IDLE;
						pulse_ff <= 1'b1;
					end
					else if (filt_ff)
						ph_cnt_ff <= ph_cnt_ff + 24'h1;
			endcase
		end
	end

	assign filt_dom   = filt_ff;
	assign wake_pulse = pulse_ff;

endmodule : cwc_wake_det

//--- logic/cwc_mode_ctrl.sv
// Purpose: Device mode, transceiver mode, SPI registers and bus wake handling
// Assumes: All pin inputs except rst asynchronous to mclk; SPI mode 0, 16-bit frames
// Notes:   Frame is 7-bit address, read-only flag, 8 data bits, MSB first

`timescale 1ns/10ps

module cwc_mode_ctrl
	import cwc_pkg::*;
#(
	parameter logic [23:0] DOM_MIN_CYC = 24'h000032,
	parameter logic [23:0] REC_MIN_CYC = 24'h000032,
	parameter logic [23:0] WAKE_TO_CYC = 24'h00c350,
	parameter logic [23:0] SILENCE_CYC = 24'h00c350
)
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe,
	input  wire logic       txd,
	input  wire logic       bus_dom,
	input  wire logic       vcc_uv,
	input  wire logic       vio_uv,
	input  wire logic       vbat_can_uv,
	input  wire logic       bat_low,
	input  wire logic       otp_warn,
	input  wire logic       otp_shut,
	output logic            rxd,
	output logic            tx_dom,
	output logic            bus_bias,
	output logic [2:0]      xcvr_state,
	output logic            regulator_inhibit_out
);

	// --------------------------------------------------------------
	// Input synchronisers
	// --------------------------------------------------------------
	logic [10:0] sync1_ff;
	logic [10:0] sync2_ff;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sync1_ff <= RST_SYNC;
			sync2_ff <= RST_SYNC;
		end
		else
		begin
			sync1_ff <= {spi_sclk, spi_cs_n, spi_mosi, txd, bus_dom, vcc_uv, vio_uv,
				vbat_can_uv, bat_low, otp_warn, otp_shut};
			sync2_ff <= sync1_ff;
		end
	end

	wire sclk_s   = sync2_ff[10];
	wire cs_n_s   = sync2_ff[9];
	wire mosi_s   = sync2_ff[8];
	wire txd_s    = sync2_ff[7];
	wire dom_s    = sync2_ff[6];
	wire vcc_uv_s = sync2_ff[5];
	wire vio_uv_s = sync2_ff[4];
	wire vbat_s   = sync2_ff[3];
	wire bat_s    = sync2_ff[2];
	wire otw_s    = sync2_ff[1];
	wire otp_s    = sync2_ff[0];

	// --------------------------------------------------------------
	// SPI slave
	// --------------------------------------------------------------
	logic        sclk_d_ff;
	logic        cs_d_ff;
	logic [4:0]  bit_cnt_ff;
	logic [15:0] shin_ff;
	logic [7:0]  shout_ff;
	logic        miso_ff;
	logic        miso_oe_ff;
	logic [7:0]  rd_data;

	wire sclk_rise = sclk_s && !sclk_d_ff;
	wire sclk_fall = !sclk_s && sclk_d_ff;
	wire cs_act    = !cs_n_s;
	wire cs_end    = cs_d_ff && !cs_act;
	wire wr_stb    = cs_end && (bit_cnt_ff == SPI_FRAME_BITS) && !shin_ff[8];
	wire [6:0] wr_addr = shin_ff[15:9];
	wire [7:0] wr_data = shin_ff[7:0];
	wire [6:0] rd_addr = shin_ff[7:1];

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sclk_d_ff <= 1'b0;
			cs_d_ff   <= 1'b0;
		end
		else
		begin
			sclk_d_ff <= sclk_s;
			cs_d_ff   <= cs_act;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst || !cs_act)
		begin
			bit_cnt_ff <= 5'h00;
			shin_ff    <= 16'h0000;
		end
		else if (sclk_rise && bit_cnt_ff != SPI_FRAME_BITS)
		begin
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
			shin_ff    <= {shin_ff[14:0], mosi_s};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst || !cs_act)
		begin
			shout_ff <= 8'h00;
			miso_ff  <= 1'b0;
		end
		else if (sclk_fall && bit_cnt_ff == SPI_HDR_BITS)
		begin
			miso_ff  <= rd_data[7];
			shout_ff <= {rd_data[6:0], 1'b0};
		end
		else if (sclk_fall)
		begin
			miso_ff  <= shout_ff[7];
			shout_ff <= {shout_ff[6:0], 1'b0};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			miso_oe_ff <= 1'b0;
		else
			miso_oe_ff <= cs_act;
	end

	// --------------------------------------------------------------
	// Control registers
	// --------------------------------------------------------------
	logic [7:0] canc_ff;
	logic [7:0] wakc_ff;
	logic       wake_evt_ff;
	logic       cause_ff;
	logic       fnp_ff;
	logic       wake_pulse;
	logic       filt_dom;

	wire [1:0] xsel      = canc_ff[1:0];
	wire       sel_wake  = canc_ff[CC_SELECTIVE_WAKE_ENABLE_BIT];
	wire       sel_ok    = canc_ff[CC_SELECTIVE_CONFIG_VALID_BIT];
	wire       wake_en   = wakc_ff[WK_EN_BIT];
	wire       wr_mode   = wr_stb && wr_addr == ADDR_MODE;
	wire       evt_clr   = wr_stb && wr_addr == ADDR_EVT && wr_data[EV_WAKE_BIT];

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			canc_ff <= RST_CANC;
			wakc_ff <= RST_WAKC;
		end
		else if (wr_stb && wr_addr == ADDR_CANC)
			canc_ff <= wr_data & 8'h33;
		else if (wr_stb && wr_addr == ADDR_WAKC)
			wakc_ff <= wr_data & 8'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			wake_evt_ff <= 1'b0;
		else
			wake_evt_ff <= wake_pulse || (wake_evt_ff && !evt_clr);
	end

	// --------------------------------------------------------------
	// Device mode
	// --------------------------------------------------------------
	cwc_dev_t   dev_ff;
	logic [7:0] boot_cnt_ff;

	wire supply_uv = vcc_uv_s || vio_uv_s;
	wire mode_sleep = wr_mode && wr_data[2:0] == MC_SLEEP;
	wire mode_stby  = wr_mode && wr_data[2:0] == MC_STANDBY;
	wire mode_norm  = wr_mode && wr_data[2:0] == MC_NORMAL;
	wire boot_done  = boot_cnt_ff == STARTUP_CYC;

	always_ff @(posedge mclk)
	begin
		if (rst || dev_ff != DM_OFF || bat_s)
			boot_cnt_ff <= 8'h00;
		else if (!boot_done)
			boot_cnt_ff <= boot_cnt_ff + 8'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			dev_ff <= DM_OFF;
		else if (bat_s)
			dev_ff <= DM_OFF;
		else
		begin
			unique case (dev_ff)
				DM_OFF:
					if (boot_done)
						dev_ff <= DM_STANDBY;
				DM_STANDBY:
					if (supply_uv || mode_sleep)
						dev_ff <= DM_SLEEP;
					else if (mode_norm)
						dev_ff <= DM_NORMAL;
				DM_NORMAL:
					if (otp_s)
						dev_ff <= DM_OVERTEMP;
					else if (supply_uv || mode_sleep)
						dev_ff <= DM_SLEEP;
					else if (mode_stby)
						dev_ff <= DM_STANDBY;
				DM_SLEEP:
					if (wake_pulse || mode_stby)
						dev_ff <= DM_STANDBY;
					else if (mode_norm)
						dev_ff <= DM_NORMAL;
				DM_OVERTEMP:
					if (!otp_s)
						dev_ff <= DM_STANDBY;
			endcase
		end
	end

	wire to_sleep = (dev_ff == DM_STANDBY || dev_ff == DM_NORMAL) && !bat_s
		&& !(dev_ff == DM_NORMAL && otp_s) && (supply_uv || mode_sleep);

	always_ff @(posedge mclk)
	begin
		if (rst)
			cause_ff <= 1'b0;
		else if (to_sleep)
			cause_ff <= supply_uv;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			fnp_ff <= 1'b1;
		else if (dev_ff == DM_NORMAL)
			fnp_ff <= 1'b0;
	end

	// --------------------------------------------------------------
	// Register read mux
	// --------------------------------------------------------------
	wire [2:0] mode_rd = (dev_ff == DM_NORMAL) ? MC_NORMAL :
		(dev_ff == DM_SLEEP) ? MC_SLEEP : MC_STANDBY;
	wire [7:0] stat_rd = {cause_ff, otw_s, fnp_ff, 5'h00};

	assign rd_data = (rd_addr == ADDR_MODE) ? {5'h00, mode_rd} :
		(rd_addr == ADDR_STAT) ? stat_rd :
		(rd_addr == ADDR_CANC) ? canc_ff :
		(rd_addr == ADDR_WAKC) ? wakc_ff :
		(rd_addr == ADDR_EVT)  ? {7'h00, wake_evt_ff} : 8'h00;

	// --------------------------------------------------------------
	// Bus activity and silence
	// --------------------------------------------------------------
	logic        filt_d_ff;
	logic [23:0] sil_cnt_ff;

	wire bus_edge = filt_dom != filt_d_ff;
	wire silent   = sil_cnt_ff > SILENCE_CYC;

	always_ff @(posedge mclk)
	begin
		if (rst)
			filt_d_ff <= 1'b0;
		else
			filt_d_ff <= filt_dom;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || bus_edge)
			sil_cnt_ff <= 24'h0;
		else if (!silent)
			sil_cnt_ff <= sil_cnt_ff + 24'h1;
	end

	// --------------------------------------------------------------
	// Transceiver mode
	// --------------------------------------------------------------
	cwc_xcv_t xcv_ff;

	wire xcv_off    = dev_ff == DM_OFF || dev_ff == DM_OVERTEMP || vbat_s;
	wire sel_active = xsel == XM_ACT_UV || xsel == XM_ACT_NUV;
	wire act_drop   = xcv_ff == XS_ACTIVE && xsel == XM_ACT_UV && vcc_uv_s;
	wire go_low     = dev_ff != DM_NORMAL || xsel == XM_OFFLINE || act_drop;
	wire act_ok     = txd_s && !vcc_uv_s;

	wire cwc_xcv_t low_next = (xcv_ff == XS_OFFLINE) ? (bus_edge ? XS_BIAS : XS_OFFLINE) :
		(silent ? XS_OFFLINE : XS_BIAS);
	wire cwc_xcv_t sel_next = (xsel == XM_LISTEN) ? XS_LISTEN :
		(xcv_ff == XS_ACTIVE) ? XS_ACTIVE :
		(act_ok ? XS_ACTIVE : XS_LISTEN);
	wire cwc_xcv_t xcv_next = xcv_off ? XS_OFF :
		(xcv_ff == XS_OFF) ? XS_OFFLINE :
		go_low ? low_next : sel_next;

	always_ff @(posedge mclk)
	begin
		if (rst)
			xcv_ff <= XS_OFF;
		else
			xcv_ff <= xcv_next;
	end

	// --------------------------------------------------------------
	// Wake pattern detector
	// --------------------------------------------------------------
	wire offline_any = xcv_ff == XS_OFFLINE || xcv_ff == XS_BIAS;
	wire det_en = offline_any && wake_en && (!sel_wake || !sel_ok);

	cwc_wake_det #(
		.DOM_MIN_CYC (DOM_MIN_CYC),
		.REC_MIN_CYC (REC_MIN_CYC),
		.WAKE_TO_CYC (WAKE_TO_CYC)
	) u_wake (
		.clk        (mclk),
		.rst        (rst),
		.enable     (det_en),
		.dom_in     (dom_s),
		.filt_dom   (filt_dom),
		.wake_pulse (wake_pulse)
	);

	// --------------------------------------------------------------
	// Pin outputs
	// --------------------------------------------------------------
	logic       rxd_ff;
	logic       tx_dom_ff;
	logic       bias_ff;
	logic       inh_ff;
	logic [2:0] xst_ff;
	cwc_dev_t   dev_d_ff;

	wire rx_live = xcv_ff == XS_ACTIVE || xcv_ff == XS_LISTEN;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rxd_ff    <= 1'b1;
			tx_dom_ff <= 1'b0;
			bias_ff   <= 1'b0;
			inh_ff    <= 1'b0;
			xst_ff    <= 3'h0;
			dev_d_ff  <= DM_OFF;
		end
		else
		begin
			rxd_ff    <= rx_live ? !dom_s : !wake_evt_ff;
			tx_dom_ff <= xcv_ff == XS_ACTIVE && !txd_s;
			bias_ff   <= rx_live || xcv_ff == XS_BIAS;
			// Inhibit lags one cycle to stay in step with the transceiver state
			dev_d_ff  <= dev_ff;
			inh_ff    <= dev_d_ff == DM_STANDBY || dev_d_ff == DM_NORMAL || dev_d_ff == DM_OVERTEMP;
			xst_ff    <= xcv_ff;
		end
	end

	assign spi_miso              = miso_ff;
	assign spi_miso_oe           = miso_oe_ff;
	assign rxd                   = rxd_ff;
	assign tx_dom                = tx_dom_ff;
	assign bus_bias              = bias_ff;
	assign xcvr_state            = xst_ff;
	assign regulator_inhibit_out = inh_ff;

endmodule : cwc_mode_ctrl

//--- tb/cwc_mode_ctrl_checker.sv
// Purpose: Port-level assertions for cwc_mode_ctrl
// Assumes: One mclk domain, synchronous rst
// Notes:   Windows allow for pin sync and registered outputs
`timescale 1ns/10ps

module cwc_mode_ctrl_checker
	import cwc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       spi_cs_n,
	input wire logic       spi_miso,
	input wire logic       spi_miso_oe,
	input wire logic       txd,
	input wire logic       bus_dom,
	input wire logic       vbat_can_uv,
	input wire logic       bat_low,
	input wire logic       rxd,
	input wire logic       tx_dom,
	input wire logic       bus_bias,
	input wire logic [2:0] xcvr_state,
	input wire logic       regulator_inhibit_out
);
	// ------------------------------------------------------------
	// Sequences and assertions
	// ------------------------------------------------------------
	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_idle_sel; spi_cs_n [*4]; endsequence
	sequence s_txd_low; !txd [*6]; endsequence
	sequence s_act_low; (xcvr_state == 3'h4 && !txd) [*6]; endsequence
	sequence s_lis_dom; (xcvr_state == 3'h3 && bus_dom) [*6]; endsequence
	sequence s_act_rec; (xcvr_state == 3'h4 && !bus_dom) [*6]; endsequence

	miso_release_a: assert property (s_idle_sel |-> !spi_miso_oe && !spi_miso)
		else $error("miso active while deselected");
	listen_hold_a: assert property (s_txd_low ##0 xcvr_state == 3'h3 |=> xcvr_state != 3'h4)
		else $error("listen left while txd low");
	tx_mode_a: assert property (tx_dom |-> xcvr_state == 3'h4 || $past(xcvr_state) == 3'h4)
		else $error("transmitter on outside active");
	tx_drive_a: assert property (s_act_low |-> tx_dom)
		else $error("txd low not driven");
	tx_quiet_a: assert property (txd [*6] |-> !tx_dom)
		else $error("dominant without txd low");
	rx_listen_a: assert property (s_lis_dom |-> !rxd)
		else $error("rxd not low in listen");
	rx_active_a: assert property (s_act_rec |-> rxd)
		else $error("rxd not high in active");
	bias_on_a: assert property ((xcvr_state inside {3'h2, 3'h3, 3'h4}) [*2] |-> bus_bias)
		else $error("bias missing");
	bias_off_a: assert property ((xcvr_state == 3'h1) [*2] |-> !bus_bias)
		else $error("bias in offline");
	off_force_a: assert property ((bat_low || vbat_can_uv) [*8] |-> xcvr_state == 3'h0)
		else $error("transceiver not off");
	inh_active_a: assert property (xcvr_state == 3'h4 |-> regulator_inhibit_out)
		else $error("active outside normal");
endmodule : cwc_mode_ctrl_checker

bind cwc_mode_ctrl cwc_mode_ctrl_checker cwc_mode_ctrl_checker_i (.mclk, .rst, .spi_cs_n, .spi_miso,
	.spi_miso_oe, .txd, .bus_dom, .vbat_can_uv, .bat_low, .rxd, .tx_dom, .bus_bias, .xcvr_state,
	.regulator_inhibit_out);

//--- tb/cwc_spi_host.sv
// Purpose: Host microcontroller model, SPI mode 0 master
// Assumes: Half period of 5 mclk
// Notes:   Released mosi shows the inverse of the last bit
`timescale 1ns/10ps

module cwc_spi_host
(
	input  wire logic mclk,
	input  wire logic miso,
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// ------------------------------------------------------------
	// Frame transfer
	// ------------------------------------------------------------
	task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		@(posedge mclk);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			mosi <= tx[i];
			repeat (5) @(posedge mclk);
			sclk <= 1'b1;
			if (i < 8)
				rx[i] = miso;
			repeat (5) @(posedge mclk);
			sclk <= 1'b0;
		end
		repeat (5) @(posedge mclk);
		cs_n <= 1'b1;
		mosi <= ~tx[0];
		repeat (6) @(posedge mclk);
	endtask : xfer
endmodule : cwc_spi_host

//--- tb/tb_top.sv
// Purpose: Self-checking bench for cwc_mode_ctrl
// Assumes: Short phase and timeout parameters
// Notes:   Random cmc and warning levels from a fixed xorshift seed
`timescale 1ns/10ps

`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin errors++; $display("[FAIL] %0t %h vs %h", $time, g, w); end end

module tb_top;
	import cwc_pkg::*;
	logic       mclk, rst, txd, bus_dom, vcc_uv, vio_uv, vbat_can_uv, bat_low, otp_warn, otp_shut;
	logic       spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, rxd, tx_dom, bus_bias;
	logic       regulator_inhibit_out;
	logic [2:0] xcvr_state;
	logic [7:0] d;
	logic [31:0] seed, r;
	int         errors, checks_done, cycles;

	cwc_mode_ctrl #(.DOM_MIN_CYC(24'h000008), .REC_MIN_CYC(24'h000008), .WAKE_TO_CYC(24'h0000c8),
		.SILENCE_CYC(24'h000064)) cwc_mode_ctrl_i (.mclk, .rst, .spi_sclk, .spi_cs_n, .spi_mosi,
		.spi_miso, .spi_miso_oe, .txd, .bus_dom, .vcc_uv, .vio_uv, .vbat_can_uv, .bat_low, .otp_warn,
		.otp_shut, .rxd, .tx_dom, .bus_bias, .xcvr_state, .regulator_inhibit_out);
	cwc_spi_host cwc_spi_host_i (.mclk, .miso(spi_miso), .sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	always #10 mclk = ~mclk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic st_ok(input logic [1:0] c, input logic [2:0] s);
		if (c == XM_OFFLINE)
			return s == 3'h1 || s == 3'h2;
		return s == ((c == XM_LISTEN) ? 3'h3 : 3'h4);
	endfunction : st_ok

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic seg(input logic v, input int n);
		bus_dom <= v;
		cyc(n);
	endtask : seg

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] x;
		cwc_spi_host_i.xfer({a, 1'b0, v}, x);
	endtask : wr

	task automatic rd(input logic [6:0] a);
		cwc_spi_host_i.xfer({a, 1'b1, 8'h00}, d);
	endtask : rd

	task automatic pat();
		seg(1'b1, 20);
		seg(1'b0, 10);
		seg(1'b1, 2);
		seg(1'b0, 12);
		seg(1'b1, 20);
		seg(1'b0, 10);
	endtask : pat

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		{mclk, bus_dom, vcc_uv, vio_uv, vbat_can_uv, bat_low, otp_warn, otp_shut} = 8'h00;
		{rst, txd} = 2'h3;
		seed = 32'h37f5;
		cyc(20);
		rst <= 1'b0;
		cyc(150);
		`CHK(xcvr_state, 3'h1)
		`CHK(regulator_inhibit_out, 1'b1)
		`CHK(spi_miso_oe, 1'b0)
		rd(ADDR_MODE); `CHK(d, 8'h04)
		rd(ADDR_STAT); `CHK(d, 8'h20)
		rd(7'h05); `CHK(d, 8'h00)
		rd(ADDR_WAKC); `CHK(d, RST_WAKC)
		wr(ADDR_WAKC, 8'h00);
		pat(); `CHK(rxd, 1'b1)
		wr(ADDR_WAKC, 8'h01);
		seg(1'b1, 20);
		seg(1'b0, 320);
		seg(1'b1, 20);
		seg(1'b0, 10); `CHK(rxd, 1'b1)
		wr(ADDR_CANC, 8'h30);
		pat(); `CHK(rxd, 1'b1)
		wr(ADDR_CANC, 8'h10);
		pat(); `CHK(rxd, 1'b0)
		rd(ADDR_EVT); `CHK(d[EV_WAKE_BIT], 1'b1)
		wr(ADDR_EVT, 8'h01); `CHK(rxd, 1'b1)
		wr(ADDR_CANC, 8'h01);
		wr(ADDR_MODE, 8'h07);
		cyc(10); `CHK(xcvr_state, 3'h4)
		rd(ADDR_STAT); `CHK(d, 8'h00)
		seg(1'b1, 8); `CHK(rxd, 1'b0)
		seg(1'b0, 8); `CHK(rxd, 1'b1)
		txd <= 1'b0;
		cyc(8); `CHK(tx_dom, 1'b1)
		txd <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			r = rnd();
			otp_warn <= r[4];
			wr(ADDR_CANC, {6'h00, r[1:0]});
			cyc(10); `CHK(st_ok(r[1:0], xcvr_state), 1'b1)
			rd(ADDR_STAT); `CHK(d[ST_OTW_BIT], r[4])
		end
		otp_warn <= 1'b0;
		wr(ADDR_CANC, 8'h00);
		txd <= 1'b0;
		wr(ADDR_CANC, 8'h01);
		cyc(10); `CHK(xcvr_state, 3'h3)
		`CHK(tx_dom, 1'b0)
		`CHK(bus_bias, 1'b1)
		seg(1'b1, 8); `CHK(rxd, 1'b0)
		seg(1'b0, 4);
		txd <= 1'b1;
		cyc(10); `CHK(xcvr_state, 3'h4)
		vcc_uv <= 1'b1;
		cyc(20);
		vcc_uv <= 1'b0;
		rd(ADDR_STAT); `CHK(d, 8'h80)
		rd(ADDR_MODE); `CHK(d, 8'h01)
		`CHK(regulator_inhibit_out, 1'b0)
		cyc(150); `CHK(xcvr_state, 3'h1)
		`CHK(bus_bias, 1'b0)
		seg(1'b1, 10);
		seg(1'b0, 6); `CHK(xcvr_state, 3'h2)
		`CHK(bus_bias, 1'b1)
		pat(); `CHK(regulator_inhibit_out, 1'b1)
		rd(ADDR_MODE); `CHK(d, 8'h04)
		wr(ADDR_EVT, 8'h01);
		wr(ADDR_MODE, 8'h01);
		rd(ADDR_STAT); `CHK(d, 8'h00)
		vbat_can_uv <= 1'b1;
		cyc(10); `CHK(xcvr_state, 3'h0)
		vbat_can_uv <= 1'b0;
		cyc(10); `CHK(xcvr_state, 3'h1)
		wr(ADDR_MODE, 8'h07);
		cyc(10);
		otp_shut <= 1'b1;
		cyc(10); `CHK(xcvr_state, 3'h0)
		`CHK(regulator_inhibit_out, 1'b1)
		otp_shut <= 1'b0;
		bat_low <= 1'b1;
		cyc(10); `CHK(regulator_inhibit_out, 1'b0)
		bat_low <= 1'b0;
		cyc(150); `CHK(xcvr_state, 3'h1)
		vio_uv <= 1'b1;
		cyc(10);
		vio_uv <= 1'b0;
		rd(ADDR_STAT); `CHK(d[ST_CAUSE_BIT], 1'b1)
		rd(ADDR_MODE); `CHK(d, 8'h01)
		conclude();
	end
endmodule : tb_top
